// ### dv/cdr_cfg_sva.sv
module cdr_cfg_sva
    import cdr_cfg_pkg::*;
(
    input wire logic       clk_sys,
    input wire logic       nrst,
    input wire reg_req_s   req,
    input wire logic [2:0] loop_mode_select,
    input wire logic       high_rate,
    input wire logic [7:0] rdata,
    input wire logic       rvalid,
    input wire logic       addr_hit,
    input wire loop_ctl_s  ctl
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    // request targets one of the seven mapped bytes
    logic mapped;
    assign mapped = req.addr inside {8'h0A, 8'h0F, 8'h10, 8'h13, 8'h14, 8'h15, 8'h16};

    a_read_answer: assert property (req.rd |=> rvalid && addr_hit == $past(mapped))
        else $error("read answer wrong");
    a_rvalid_idle: assert property (!req.rd |=> !rvalid)
        else $error("stray read valid");
    a_unmapped_zero: assert property (req.rd && !mapped |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    a_bw_reset: assert property ($rose(nrst) |-> ctl.loop_bw_scale == 3'h4 && ctl.ref_osc_power_down)
        else $error("reset controls wrong");
    a_ref_gate: assert property (ctl.ref_osc_enable |-> !ctl.ref_osc_power_down && ctl.reference_locked_mode)
        else $error("reference enabled while off");
    a_edge_decode: assert property (ctl.edge_rise_en == (ctl.edge_mode != edges_fall)
        && ctl.edge_fall_en == (ctl.edge_mode != edges_rise))
        else $error("edge decode wrong");
    a_slice_off: assert property (ctl.slice_enable == (ctl.slice_level != 7'h00))
        else $error("slice enable wrong");
    a_band_divide: assert property (ctl.ref_divide == (8'h01 << ctl.ref_freq_band))
        else $error("band divide wrong");
    a_ratio_write: assert property (req.wr && req.addr == 8'h0F |-> ##2
        ctl.rate_divide_code == $past(req.wdata[3:0], 2) && ctl.ref_freq_band == $past(req.wdata[5:4], 2)
        && ctl.lock_loss_compare_source == $past(req.wdata[6], 2))
        else $error("lock setup not applied");
    a_slew_write: assert property (req.wr && req.addr == 8'h13 |-> ##2
        {ctl.auto_slice_on, ctl.dll_slew} == $past(req.wdata[2:0], 2))
        else $error("slew not applied");
    a_slice_write: assert property (req.wr && req.addr == 8'h15 |-> ##2
        {ctl.slice_extended, ctl.slice_level} == $past(req.wdata, 2))
        else $error("slice not applied");
    a_input_write: assert property (req.wr && req.addr == 8'h16 |-> ##2 {ctl.term_float,
        ctl.front_end, ctl.auto_equalize_on, ctl.equalizer_gain} == $past(req.wdata, 2))
        else $error("input stage not applied");
    a_phase_rate: assert property (!high_rate [*6] |-> ctl.sample_phase == 4'h0)
        else $error("phase offset at low rate");
endmodule

// ### dv/mgmt_host_model.sv
module mgmt_host_model
    import cdr_cfg_pkg::*;
(
    input wire logic clk_sys,
    output reg_req_s req
);
    timeunit 1ns;
    timeprecision 1ps;

    initial req = '0;

    // one access per cycle, launched just after the edge and held until the next
    task automatic access(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #1;
        req = '{wr: w, rd: r, addr: a, wdata: d};
    endtask
endmodule

// ### dv/tb.sv
`include "cdr_cfg_defines.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end

module tb;
    import cdr_cfg_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk_sys;
    logic       nrst;
    logic       high_rate;
    logic [2:0] loop_mode_select;
    logic       rvalid;
    logic [7:0] rdata;
    logic [7:0] d;
    logic [7:0] exp_v;
    reg_req_s   req;
    loop_ctl_s  ctl;
    int         n_errors = 0;
    int         n_compared = 0;
    logic [7:0] expq[$];
    logic [7:0] ofs[7] = '{`OFS_REF_CLOCK_CONTROL, `OFS_REF_LOCK_SETUP, `OFS_LOOP_EDGE_BW,
        `OFS_LOOP_SLICE_SLEW, `OFS_SAMPLE_PHASE, `OFS_SLICE_THRESHOLD, `OFS_INPUT_STAGE};
    logic [7:0] rst[7] = '{8'h05, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] msk[7] = '{8'h04, 8'h7F, 8'h1F, 8'h07, 8'h0F, 8'hFF, 8'hFF};

    initial
    begin
        clk_sys = 0;
        forever #2 clk_sys = ~clk_sys;
    end

    mgmt_host_model mgmt_host_model_inst (.clk_sys(clk_sys), .req(req));
    cdr_loop_input_config_regs cdr_loop_input_config_regs_inst (.clk_sys(clk_sys), .nrst(nrst),
        .req(req), .loop_mode_select(loop_mode_select), .high_rate(high_rate), .rdata(rdata),
        .rvalid(rvalid), .addr_hit(), .ctl(ctl));

    task automatic stop_test();
        if (n_errors == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // reads note their expected byte; the monitor below settles it
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        mgmt_host_model_inst.access(1'b0, 1'b1, a, 8'h00);
        expq.push_back(e);
    endtask

    // each answered read takes the oldest note
    always @(posedge clk_sys)
    begin
        if (rvalid === 1'b1)
        begin
            exp_v = (expq.size() > 0) ? expq.pop_front() : 8'hXX;
            `CHK("rdata", exp_v, rdata)
        end
    end

    initial
    begin
        repeat (20000) @(posedge clk_sys);
        `CHK("timeout", 0, 1)
        stop_test();
    end

    initial
    begin
        void'($urandom(77165));
        nrst = 0;
        loop_mode_select = 3'h0;
        high_rate = 0;
        repeat (4) @(posedge clk_sys);
        #1 nrst = 1;
        // reset values, then an unmapped hole
        for (int i = 0; i < 7; i++)
            rd(ofs[i], rst[i]);
        rd(8'h11, 8'h00);
        // random writes, each read back at once with reserved bits forced
        repeat (20)
            for (int i = 0; i < 7; i++)
            begin
                d = 8'($urandom);
                if (i == 6 && d[6:5] == 2'b11)
                    d[6] = 1'b0; // undefined input select is never written
                d = (d & msk[i]) | (i == 0 ? `FIX_REF_CLOCK_CONTROL : 8'h00);
                mgmt_host_model_inst.access(1'b1, 1'b0, ofs[i], d);
                rd(ofs[i], d);
            end
        // ratio, band and edge decode table
        for (int k = 0; k < 10; k++)
        begin
            mgmt_host_model_inst.access(1'b1, 1'b0, 8'h0F, {2'b00, 2'(k), 4'(k)});
            mgmt_host_model_inst.access(1'b1, 1'b0, 8'h10, {3'b000, 2'(k), 3'h4});
            mgmt_host_model_inst.access(1'b0, 1'b0, 8'h00, 8'h00);
            repeat (3) @(posedge clk_sys);
            #1;
            `CHK("ratio", 10'(1) << k, ctl.rate_divide_times2)
            `CHK("band", 8'(1) << (k % 4), ctl.ref_divide)
            `CHK("rise", k % 4 != 2, ctl.edge_rise_en)
            `CHK("fall", k % 4 != 1, ctl.edge_fall_en)
        end
        // reference mode with the oscillator powered, high data rate
        mgmt_host_model_inst.access(1'b1, 1'b0, 8'h0A, 8'h01);
        mgmt_host_model_inst.access(1'b1, 1'b0, 8'h14, 8'h0B);
        mgmt_host_model_inst.access(1'b0, 1'b0, 8'h00, 8'h00);
        loop_mode_select = 3'h2;
        high_rate = 1;
        repeat (8) @(posedge clk_sys);
        #1;
        `CHK("ref_en", 1'b1, ctl.ref_osc_enable)
        `CHK("phase", 4'hB, ctl.sample_phase)
        loop_mode_select = 3'h0;
        high_rate = 0;
        repeat (8) @(posedge clk_sys);
        #1;
        `CHK("ref_en", 1'b0, ctl.ref_osc_enable)
        `CHK("phase", 4'h0, ctl.sample_phase)
        for (int t = 0; t < 20 && expq.size() > 0; t++)
            @(posedge clk_sys);
        `CHK("drain", 0, expq.size())
        stop_test();
    end
endmodule

bind cdr_loop_input_config_regs cdr_cfg_sva cdr_cfg_sva_inst (.clk_sys(clk_sys), .nrst(nrst),
    .req(req), .loop_mode_select(loop_mode_select), .high_rate(high_rate), .rdata(rdata),
    .rvalid(rvalid), .addr_hit(addr_hit), .ctl(ctl));

// ### rtl/cdr_cfg_defines.svh
`ifndef CDR_CFG_DEFINES_SVH
`define CDR_CFG_DEFINES_SVH

// register offsets
`define OFS_REF_CLOCK_CONTROL 8'h0A
`define OFS_REF_LOCK_SETUP    8'h0F
`define OFS_LOOP_EDGE_BW      8'h10
`define OFS_LOOP_SLICE_SLEW   8'h13
`define OFS_SAMPLE_PHASE      8'h14
`define OFS_SLICE_THRESHOLD   8'h15
`define OFS_INPUT_STAGE       8'h16

// reset values
`define RST_REF_CLOCK_CONTROL 8'h05
`define RST_REF_LOCK_SETUP    8'h00
`define RST_LOOP_EDGE_BW      8'h04
`define RST_LOOP_SLICE_SLEW   8'h00
`define RST_SAMPLE_PHASE      8'h00
`define RST_SLICE_THRESHOLD   8'h00
`define RST_INPUT_STAGE       8'h00

// writable bit masks; other bits hold fixed reserved values
`define MSK_REF_CLOCK_CONTROL 8'h04
`define FIX_REF_CLOCK_CONTROL 8'h01
`define MSK_REF_LOCK_SETUP    8'h7F
`define MSK_LOOP_EDGE_BW      8'h1F
`define MSK_LOOP_SLICE_SLEW   8'h07
`define MSK_SAMPLE_PHASE      8'h0F
`define MSK_SLICE_THRESHOLD   8'hFF
`define MSK_INPUT_STAGE       8'hFF

// field positions
`define BIT_REF_PDN      2
`define BIT_LOCK_CMP     6
`define BIT_AUTO_SLICE   2
`define BIT_EXT_SLICE    7
`define BIT_TERM_FLOAT   7
`define BIT_AUTO_EQ      4

// loop mode codes
`define MODE_LOCK_DATA   3'h0
`define MODE_LOCK_REF    3'h2

// bandwidth scale divisor
`define BW_SCALE_DIV     4

`endif

// ### rtl/cdr_cfg_pkg.sv
package cdr_cfg_pkg;

    typedef enum logic [1:0] {
        edges_both,
        edges_rise,
        edges_fall
    } edge_mode_e;

    typedef enum logic [1:0] {
        front_limiter,
        front_equalizer,
        front_buffer,
        front_invalid
    } front_end_e;

    // register access request from the management host
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    // all control outputs toward loop and front end
    typedef struct packed {
        logic       ref_osc_power_down;
        logic       ref_osc_enable;
        logic       reference_locked_mode;
        logic       lock_loss_compare_source;
        logic [1:0] ref_freq_band;
        logic [3:0] rate_divide_code;
        logic [9:0] rate_divide_times2;
        logic [7:0] ref_divide;
        edge_mode_e edge_mode;
        logic       edge_rise_en;
        logic       edge_fall_en;
        logic [2:0] loop_bw_scale;
        logic       auto_slice_on;
        logic [1:0] dll_slew;
        logic [3:0] sample_phase;
        logic       sample_phase_active;
        logic       slice_extended;
        logic [6:0] slice_level;
        logic       slice_enable;
        logic       term_float;
        front_end_e front_end;
        logic       auto_equalize_on;
        logic [3:0] equalizer_gain;
    } loop_ctl_s;

endpackage

// ### rtl/cdr_loop_input_config_regs.sv
`include "cdr_cfg_defines.svh"

module cdr_loop_input_config_regs
    import cdr_cfg_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       nrst,
    input  wire reg_req_s   req,
    input  wire logic [2:0] loop_mode_select,
    input  wire logic       high_rate,
    output logic [7:0]      rdata,
    output logic            rvalid,
    output logic            addr_hit,
    output loop_ctl_s       ctl
);

    typedef struct packed {
        logic [7:0] ref_ctl;
        logic [7:0] ref_lock;
        logic [7:0] edge_bw;
        logic [7:0] slice_slew;
        logic [7:0] phase;
        logic [7:0] slice;
        logic [7:0] stage;
        logic [2:0] mode_q1;
        logic [2:0] mode_q2;
        logic [2:0] mode_q3;
        logic       rate_q1;
        logic       rate_q2;
        logic       rate_q3;
        logic [2:0] mode;
        logic       rate;
        logic [7:0] rdata;
        logic       rvalid;
        logic       addr_hit;
        loop_ctl_s  ctl;
    } state_s;

    state_s st;
    state_s next_st;

    // masked write: only writable bits change, reserved bits keep fixed value
    function automatic logic [7:0] merge(input logic [7:0] wd,
                                         input logic [7:0] msk,
                                         input logic [7:0] fix);
        merge = (wd & msk) | (fix & ~msk);
    endfunction

    // register read-back mux; returns hit flag in bit 8
    function automatic logic [8:0] lookup(input logic [7:0] a, input state_s s);
        case (a)
            `OFS_REF_CLOCK_CONTROL: lookup = {1'b1, s.ref_ctl};
            `OFS_REF_LOCK_SETUP:    lookup = {1'b1, s.ref_lock};
            `OFS_LOOP_EDGE_BW:      lookup = {1'b1, s.edge_bw};
            `OFS_LOOP_SLICE_SLEW:   lookup = {1'b1, s.slice_slew};
            `OFS_SAMPLE_PHASE:      lookup = {1'b1, s.phase};
            `OFS_SLICE_THRESHOLD:   lookup = {1'b1, s.slice};
            `OFS_INPUT_STAGE:       lookup = {1'b1, s.stage};
            default:                lookup = 9'h000;
        endcase
    endfunction

    always_comb
    begin
        logic [8:0] hit;
        logic       ref_mode;
        hit      = 9'h000;
        ref_mode = 1'b0;
        next_st  = st;

        // pin straps pass three flops; change accepted once q2 and q3 agree
        next_st.mode_q1 = loop_mode_select;
        next_st.mode_q2 = st.mode_q1;
        next_st.mode_q3 = st.mode_q2;
        if (st.mode_q2 == st.mode_q3)
        begin
            next_st.mode = st.mode_q3;
        end
        next_st.rate_q1 = high_rate;
        next_st.rate_q2 = st.rate_q1;
        next_st.rate_q3 = st.rate_q2;
        if (st.rate_q2 == st.rate_q3)
        begin
            next_st.rate = st.rate_q3;
        end

        // host writes, reserved bits forced to their fixed values
        if (req.wr)
        begin
            case (req.addr)
                `OFS_REF_CLOCK_CONTROL: next_st.ref_ctl = merge(req.wdata,
                    `MSK_REF_CLOCK_CONTROL, `FIX_REF_CLOCK_CONTROL);
                `OFS_REF_LOCK_SETUP:    next_st.ref_lock = merge(req.wdata,
                    `MSK_REF_LOCK_SETUP, 8'h00);
                `OFS_LOOP_EDGE_BW:      next_st.edge_bw = merge(req.wdata,
                    `MSK_LOOP_EDGE_BW, 8'h00);
                `OFS_LOOP_SLICE_SLEW:   next_st.slice_slew = merge(req.wdata,
                    `MSK_LOOP_SLICE_SLEW, 8'h00);
                `OFS_SAMPLE_PHASE:      next_st.phase = merge(req.wdata,
                    `MSK_SAMPLE_PHASE, 8'h00);
                `OFS_SLICE_THRESHOLD:   next_st.slice = req.wdata;
                `OFS_INPUT_STAGE:       next_st.stage = req.wdata;
                default:                next_st.rdata = st.rdata;
            endcase
        end

        // read answer one cycle after request
        hit              = lookup(req.addr, st);
        next_st.rvalid   = req.rd;
        next_st.addr_hit = (req.rd | req.wr) & hit[8];
        if (req.rd)
        begin
            next_st.rdata = hit[7:0];
        end

        // decoded controls follow the registers, registered one cycle later
        ref_mode = (st.mode == `MODE_LOCK_REF);
        next_st.ctl.reference_locked_mode = ref_mode;
        next_st.ctl.ref_osc_power_down = st.ref_ctl[`BIT_REF_PDN];
        next_st.ctl.ref_osc_enable = ~st.ref_ctl[`BIT_REF_PDN] & ref_mode;
        next_st.ctl.lock_loss_compare_source = st.ref_lock[`BIT_LOCK_CMP];
        next_st.ctl.ref_freq_band = st.ref_lock[5:4];
        next_st.ctl.rate_divide_code = st.ref_lock[3:0];
        // ratio held as twice its value so code 0 (one half) stays integral
        if (st.ref_lock[3:0] <= 4'hA)
        begin
            next_st.ctl.rate_divide_times2 = 10'(10'h001 << st.ref_lock[3:0]);
        end
        else
        begin
            next_st.ctl.rate_divide_times2 = 10'h200; // clamp above code 1010
        end
        // reference divider toward the base band; loop compares after both divides
        next_st.ctl.ref_divide = 8'(8'h01 << st.ref_lock[5:4]);

        case (st.edge_bw[4:3])
            2'b01:   next_st.ctl.edge_mode = edges_rise;
            2'b10:   next_st.ctl.edge_mode = edges_fall;
            default: next_st.ctl.edge_mode = edges_both;
        endcase
        next_st.ctl.edge_rise_en = (st.edge_bw[4:3] != 2'b10);
        next_st.ctl.edge_fall_en = (st.edge_bw[4:3] != 2'b01);
        next_st.ctl.loop_bw_scale = st.edge_bw[2:0]; // scale = field / 4

        next_st.ctl.auto_slice_on = st.slice_slew[`BIT_AUTO_SLICE];
        next_st.ctl.dll_slew = st.slice_slew[1:0];

        next_st.ctl.sample_phase = st.rate ? st.phase[3:0] : 4'h0;
        next_st.ctl.sample_phase_active = st.rate;

        next_st.ctl.slice_extended = st.slice[`BIT_EXT_SLICE];
        next_st.ctl.slice_level = st.slice[6:0];
        next_st.ctl.slice_enable = (st.slice[6:0] != 7'h00);

        next_st.ctl.term_float = st.stage[`BIT_TERM_FLOAT];
        next_st.ctl.front_end = front_end_e'(st.stage[6:5]);
        next_st.ctl.auto_equalize_on = st.stage[`BIT_AUTO_EQ];
        next_st.ctl.equalizer_gain = st.stage[3:0];
    end

    // state register with synchronous reset
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            st            <= '0;
            st.ref_ctl    <= `RST_REF_CLOCK_CONTROL; // reference clock off
            st.ref_lock   <= `RST_REF_LOCK_SETUP;
            st.edge_bw    <= `RST_LOOP_EDGE_BW;
            st.slice_slew <= `RST_LOOP_SLICE_SLEW;
            st.phase      <= `RST_SAMPLE_PHASE;
            st.slice      <= `RST_SLICE_THRESHOLD;
            st.stage      <= `RST_INPUT_STAGE;
            st.ctl.ref_osc_power_down <= 1'b1;
            st.ctl.loop_bw_scale      <= 3'h4;
            st.ctl.edge_rise_en       <= 1'b1;
            st.ctl.edge_fall_en       <= 1'b1;
            st.ctl.rate_divide_times2 <= 10'h001;
            st.ctl.ref_divide         <= 8'h01;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign rdata    = st.rdata;
    assign rvalid   = st.rvalid;
    assign addr_hit = st.addr_hit;
    assign ctl      = st.ctl;

endmodule
